// file: ccm_cfg_regs.sv
// Registers 4 to 9 of the clock multiplier and the logic they steer:
// selection method, history settings, output formats, sleep, hold.
// Assumes the serial host port presents decoded single-cycle accesses.
`timescale 1ns/10ps
`default_nettype none
module ccm_cfg_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire ccm_pkg::ccm_reg_req_type regReq,
  input wire ccm_pkg::ccm_sel_ctrl_type selCtrl,
  input wire logic clockInAValid,
  input wire logic clockInBValid,
  input wire logic [ccm_pkg::NUM_OUT-1:0] pllClk,
  output logic [ccm_pkg::DATA_W-1:0] rdData,
  output logic rdValid,
  output ccm_pkg::ccm_method_type selectMethod,
  output logic [ccm_pkg::HIST_W-1:0] historyDelay,
  output logic [ccm_pkg::HIST_W-1:0] historyAveraging,
  output logic [1:0] cmosDriveLevel,
  output logic sleepMode,
  output ccm_pkg::ccm_format_type outAFormat,
  output ccm_pkg::ccm_format_type outBFormat,
  output logic [2:0] offsetAlarmReference,
  output logic [ccm_pkg::NUM_OUT-1:0] bypassAllowed,
  output ccm_pkg::ccm_input_type activeInput,
  output logic digitalHold,
  output logic [ccm_pkg::NUM_OUT-1:0] clockOut,
  output logic [ccm_pkg::NUM_OUT-1:0] outHolding
);
  import ccm_pkg::*;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [DATA_W-1:0] selHist_q;
  logic [DATA_W-1:0] drive_q;
  logic [DATA_W-1:0] format_q;
  logic [DATA_W-1:0] alarmRef_q;
  logic [DATA_W-1:0] staticHold_q;
  logic [DATA_W-1:0] histAvg_q;

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] wr,
    input logic [DATA_W-1:0] mask);
    return (old & ~mask) | (wr & mask);
  endfunction : merge

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selHist_q <= RST_SEL_HIST;
      drive_q <= RST_DRIVE;
      format_q <= RST_FORMAT;
      alarmRef_q <= RST_ALARM_REF;
      staticHold_q <= RST_STATIC_HOLD;
      histAvg_q <= RST_HISTORY_AVERAGING;
    end else if (regReq.wrEn) begin
      // Reserved bits keep their reset value
      unique case (regReq.addr)
        ADDR_SEL_HIST: begin
          selHist_q <= merge(selHist_q, regReq.wrData, WMASK_SEL_HIST);
        end
        ADDR_DRIVE: begin
          drive_q <= merge(drive_q, regReq.wrData, WMASK_DRIVE);
        end
        ADDR_FORMAT: begin
          format_q <= merge(format_q, regReq.wrData, WMASK_FORMAT);
        end
        ADDR_ALARM_REF: begin
          alarmRef_q <= merge(alarmRef_q, regReq.wrData,
                              WMASK_ALARM_REF);
        end
        ADDR_STATIC_HOLD: begin
          staticHold_q <= merge(staticHold_q, regReq.wrData,
                                WMASK_STATIC_HOLD);
        end
        ADDR_HISTORY_AVERAGING: begin
          histAvg_q <= merge(histAvg_q, regReq.wrData,
                             WMASK_HISTORY_AVERAGING);
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Read port: data one cycle after the request
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= RD_UNMAPPED;
      rdValid <= 1'b0;
    end else begin
      rdValid <= regReq.rdEn;
      if (regReq.rdEn) begin
        unique case (regReq.addr)
          ADDR_SEL_HIST: rdData <= selHist_q;
          ADDR_DRIVE: rdData <= drive_q;
          ADDR_FORMAT: rdData <= format_q;
          ADDR_ALARM_REF: rdData <= alarmRef_q;
          ADDR_STATIC_HOLD: rdData <= staticHold_q;
          ADDR_HISTORY_AVERAGING: rdData <= histAvg_q;
          default: rdData <= RD_UNMAPPED;
        endcase
      end
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************
  ccm_method_type methodField;
  ccm_format_type fmtField [NUM_OUT];
  ccm_hold_type holdField [NUM_OUT];
  logic sleepField;

  always_comb begin
    methodField = ccm_method_type'(selHist_q[METHOD_LSB +: 2]);
    sleepField = format_q[SLEEP_BIT];
    fmtField[0] = ccm_format_type'(format_q[FMT_A_LSB +: 3]);
    fmtField[1] = ccm_format_type'(format_q[FMT_B_LSB +: 3]);
    holdField[0] = ccm_hold_type'(staticHold_q[HOLD_A_LSB +: 2]);
    holdField[1] = ccm_hold_type'(staticHold_q[HOLD_B_LSB +: 2]);
  end

  // Configuration outputs registered from the fields
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selectMethod <= METH_MANUAL;
      historyDelay <= '0;
      historyAveraging <= '0;
      cmosDriveLevel <= '0;
      sleepMode <= 1'b0;
      offsetAlarmReference <= '0;
    end else begin
      selectMethod <= methodField;
      historyDelay <= selHist_q[HDELAY_LSB +: HIST_W];
      historyAveraging <= histAvg_q[HAVG_LSB +: HIST_W];
      cmosDriveLevel <= drive_q[DRIVE_LSB +: 2];
      sleepMode <= sleepField;
      offsetAlarmReference <= alarmRef_q[ALARM_LSB +: 3];
    end
  end

  // ************************************************************
  // Effective output formats
  // ************************************************************
  ccm_format_type effFmt [NUM_OUT];
  logic [NUM_OUT-1:0] outOff;

  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      effFmt[i] = sleepField ? FMT_DISABLE : fmtField[i];
      outOff[i] = (effFmt[i] == FMT_DISABLE);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outAFormat <= FMT_DISABLE;
      outBFormat <= FMT_DISABLE;
      bypassAllowed <= '0;
    end else begin
      outAFormat <= effFmt[0];
      outBFormat <= effFmt[1];
      for (int i = 0; i < NUM_OUT; i++) begin
        // Only differential formats carry the bypass path
        bypassAllowed[i] <= !outOff[i] && (effFmt[i] != FMT_CMOS) &&
                            (effFmt[i] != FMT_RSVD0) &&
                            (effFmt[i] != FMT_RSVD4);
      end
    end
  end

  // ************************************************************
  // Clock outputs with static hold
  // ************************************************************
  generate
    for (genvar g = 0; g < NUM_OUT; g++) begin : gOut
      ccm_out_hold uHold (
        .clk(clk),
        .arst_n(arst_n),
        .srcClk(pllClk[g]),
        .holdCode(holdField[g]),
        .outOff(outOff[g]),
        .outClk(clockOut[g]),
        .holding(outHolding[g])
      );
    end
  endgenerate

  // ************************************************************
  // Input selection
  // ************************************************************
  ccm_input_selector uSel (
    .clk(clk),
    .arst_n(arst_n),
    .method(methodField),
    .ctrl(selCtrl),
    .validA(clockInAValid),
    .validB(clockInBValid),
    .activeInput(activeInput),
    .digitalHold(digitalHold)
  );

endmodule : ccm_cfg_regs
`default_nettype wire

// file: ccm_cfg_regs_sva.sv
// Assertion checker for the clock-select and output-format registers.
// Assumes it is bound to ccm_cfg_regs and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module ccm_cfg_regs_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire ccm_pkg::ccm_reg_req_type regReq,
  input wire ccm_pkg::ccm_sel_ctrl_type selCtrl,
  input wire logic clockInAValid,
  input wire logic [ccm_pkg::DATA_W-1:0] rdData,
  input wire logic rdValid,
  input wire ccm_pkg::ccm_method_type selectMethod,
  input wire logic [ccm_pkg::HIST_W-1:0] historyDelay,
  input wire logic sleepMode,
  input wire ccm_pkg::ccm_format_type outAFormat,
  input wire ccm_pkg::ccm_format_type outBFormat,
  input wire logic [ccm_pkg::NUM_OUT-1:0] bypassAllowed,
  input wire ccm_pkg::ccm_input_type activeInput,
  input wire logic digitalHold,
  input wire logic [ccm_pkg::NUM_OUT-1:0] clockOut,
  input wire logic [ccm_pkg::NUM_OUT-1:0] outHolding
);
  import ccm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire wr04 = regReq.wrEn && regReq.addr == ADDR_SEL_HIST;
  wire calm = !selCtrl.forceHold && !wr04;
  // ********
  // Assertions and covers
  // ********
  AST_RSVD_DRIVE: assert property (
    regReq.rdEn && regReq.addr == ADDR_DRIVE |=>
    rdValid && rdData[5:0] == RST_DRIVE[5:0])
    else $error("reserved drive bits changed");
  AST_RSVD_SELECT: assert property (
    regReq.rdEn && regReq.addr == ADDR_SEL_HIST |=> rdValid && !rdData[5])
    else $error("reserved select bit set");
  AST_METHOD_DELAY: assert property (
    wr04 ##1 !wr04 |=> selectMethod == $past(regReq.wrData[7:6], 2) &&
    historyDelay == $past(regReq.wrData[4:0], 2))
    else $error("method or delay not applied");
  AST_SLEEP_OFF: assert property (
    sleepMode |-> outAFormat == FMT_DISABLE && outBFormat == FMT_DISABLE &&
    bypassAllowed == 2'h0)
    else $error("sleep left an output on");
  AST_BYPASS: assert property (
    bypassAllowed[0] == !(outAFormat inside {FMT_DISABLE, FMT_CMOS}) &&
    bypassAllowed[1] == !(outBFormat inside {FMT_DISABLE, FMT_CMOS}))
    else $error("bypass offered on wrong format");
  AST_FORCE_HOLD: assert property (selCtrl.forceHold |=> digitalHold)
    else $error("force hold ignored");
  AST_REVERT: assert property (
    calm && $stable(selectMethod) && !$past(wr04) &&
    selectMethod == METH_AUTO_REV && !$past(selCtrl.forceHold) &&
    clockInAValid && selCtrl.firstPriorityInput == IN_A |=> activeInput == IN_A)
    else $error("no return to first priority");
  AST_MANUAL: assert property (
    calm && $stable(selectMethod) && !$past(wr04) &&
    selectMethod == METH_MANUAL && !selCtrl.pinSelectEnable &&
    $stable(selCtrl) |=> activeInput == $past(selCtrl.registerInputChoice))
    else $error("manual choice not followed");
  AST_HOLD_STATIC: assert property (
    (outHolding[0] [*2] |-> $stable(clockOut[0])) and
    (outHolding[1] [*2] |-> $stable(clockOut[1])))
    else $error("held output moved");
  COV_HOLD: cover property (digitalHold);
  COV_HIGH: cover property (outHolding[1] && clockOut[1]);
  COV_REV: cover property (selectMethod == METH_AUTO_REV && activeInput == IN_B);
endmodule : ccm_cfg_regs_sva
bind ccm_cfg_regs ccm_cfg_regs_sva u_sva (
  .clk, .arst_n, .regReq, .selCtrl, .clockInAValid, .rdData, .rdValid,
  .selectMethod, .historyDelay, .sleepMode, .outAFormat, .outBFormat,
  .bypassAllowed, .activeInput, .digitalHold, .clockOut, .outHolding
);
`default_nettype wire

// file: ccm_host_model.sv
// Host model: one register access at a time on the request port.
// Assumes the read answer stands in the cycle after the taking edge.
`timescale 1ns/10ps
`default_nettype none
module ccm_host_model (
  input wire logic clk,
  input wire logic [ccm_pkg::DATA_W-1:0] rdData,
  input wire logic rdValid,
  output var ccm_pkg::ccm_reg_req_type regReq
);
  import ccm_pkg::*;
  initial regReq = '0;
  task automatic acc(input logic we, re, input logic [7:0] a, d,
                     output logic [7:0] q, output logic v);
    @(posedge clk);
    regReq <= '{we, re, a, d};
    @(posedge clk);
    // Released enables go low; address and data show the inverse of the last value
    regReq <= '{1'b0, 1'b0, ~a, ~d};
    @(negedge clk);
    q = rdData;
    v = rdValid;
  endtask : acc
endmodule : ccm_host_model
`default_nettype wire

// file: ccm_input_selector.sv
// Input clock selection: manual, automatic revertive and non-revertive,
// with forced digital hold. Assumes input validity flags are synchronous.
`timescale 1ns/10ps
`default_nettype none
module ccm_input_selector (
  input wire logic clk,
  input wire logic arst_n,
  input wire ccm_pkg::ccm_method_type method,
  input wire ccm_pkg::ccm_sel_ctrl_type ctrl,
  input wire logic validA,
  input wire logic validB,
  output ccm_pkg::ccm_input_type activeInput,
  output logic digitalHold
);
  import ccm_pkg::*;

  ccm_sel_state_type state_q;
  ccm_sel_state_type state_d;
  logic firstValid;
  logic secondValid;
  logic autoMode;
  ccm_input_type manualPick;

  function automatic logic validOf(input logic [1:0] code, input logic a,
                                   input logic b);
    return (code == IN_B) ? b : a;
  endfunction : validOf

  always_comb begin
    firstValid = validOf(ctrl.firstPriorityInput, validA, validB);
    secondValid = validOf(ctrl.secondPriorityInput, validA, validB);
    autoMode = (method == METH_AUTO_NONREV) || (method == METH_AUTO_REV);
    manualPick = ccm_input_type'(ctrl.registerInputChoice);
    if (ctrl.pinSelectEnable) begin
      manualPick = ctrl.selectPin ? IN_B : IN_A;
    end
  end

  always_comb begin
    state_d = state_q;
    if (ctrl.forceHold) begin
      state_d = SEL_HOLD;
    end else if (method == METH_MANUAL) begin
      state_d = SEL_MANUAL;
    end else if (autoMode) begin
      unique case (state_q)
        SEL_FIRST: begin
          if (!firstValid) begin
            state_d = secondValid ? SEL_SECOND : SEL_HOLD;
          end
        end
        SEL_SECOND: begin
          if (method == METH_AUTO_REV && firstValid) begin
            state_d = SEL_FIRST;
          end else if (!secondValid) begin
            state_d = firstValid ? SEL_FIRST : SEL_HOLD;
          end
        end
        SEL_HOLD, SEL_MANUAL: begin
          if (firstValid) begin
            state_d = SEL_FIRST;
          end else if (secondValid) begin
            state_d = SEL_SECOND;
          end else begin
            state_d = SEL_HOLD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SEL_MANUAL;
    end else begin
      state_q <= state_d;
    end
  end

  // Hold keeps the last input reported
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      activeInput <= IN_A;
      digitalHold <= 1'b0;
    end else begin
      digitalHold <= (state_d == SEL_HOLD);
      unique case (state_d)
        SEL_FIRST: activeInput <= ccm_input_type'(ctrl.firstPriorityInput);
        SEL_SECOND: activeInput <= ccm_input_type'(ctrl.secondPriorityInput);
        SEL_MANUAL: activeInput <= manualPick;
        SEL_HOLD: activeInput <= activeInput;
      endcase
    end
  end

endmodule : ccm_input_selector
`default_nettype wire

// file: ccm_out_hold.sv
// One clock output with glitch-free static hold and disable.
// Assumes the source clock level is sampled synchronously to clk.
`timescale 1ns/10ps
`default_nettype none
module ccm_out_hold (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic srcClk,
  input wire ccm_pkg::ccm_hold_type holdCode,
  input wire logic outOff,
  output logic outClk,
  output logic holding
);
  import ccm_pkg::*;

  ccm_hold_type mode_q;
  ccm_hold_type req;
  logic reqLevel;
  logic curLevel;

  function automatic logic levelOf(input ccm_hold_type m, input logic s);
    logic r;
    r = s;
    if (m == HOLD_LOW) begin
      r = 1'b0;
    end else if (m == HOLD_HIGH) begin
      r = 1'b1;
    end
    return r;
  endfunction : levelOf

  // Disable parks low; reserved code keeps the present mode
  always_comb begin
    req = mode_q;
    if (outOff) begin
      req = HOLD_LOW;
    end else if (holdCode != HOLD_RSVD) begin
      req = holdCode;
    end
    reqLevel = levelOf(req, srcClk);
    curLevel = levelOf(mode_q, srcClk);
  end

  // Switch only when old and new levels agree: no runt pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= HOLD_NONE;
    end else if (reqLevel == curLevel) begin
      mode_q <= req;
    end else if (mode_q != HOLD_NONE && req != HOLD_NONE &&
                 srcClk == curLevel) begin
      // Low to high or back: pass through follow, no short pulse
      mode_q <= HOLD_NONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outClk <= 1'b0;
      holding <= 1'b0;
    end else begin
      outClk <= curLevel;
      holding <= (mode_q != HOLD_NONE);
    end
  end

endmodule : ccm_out_hold
`default_nettype wire

// file: ccm_pkg.sv
// Constants, field layouts and carrier types for the clock-select and
// output-format configuration registers (addresses 4 to 9).
// Assumes a single 20 MHz clock and an active-low asynchronous reset.
//
// What this block does
// - Method field picks manual, auto non-revertive, revertive
// - History delay field drives digital-hold history delay
// - History averaging field drives digital-hold averaging time
// - CMOS drive field picks one of four strengths
// - Sleep disables both outputs, overriding formats
// - Output B format field decodes signal format
// - Output A format uses the same encoding
// - CMOS outputs never offer PLL bypass
// - Alarm reference field picks crystal, input A, B
// - Output B hold field forces low or high
// - Output A hold field forces low or high
// - Hold entry and exit are glitch free
// - Register 4 resets to 0x12
// - Register 5 resets to 0xED
// - Register 8 resets to all zeros
// - Register 9 resets to 0xC0
// - Manual mode uses register choice or pin
// - Priority fields name first and second input
// - Force hold overrides all selection and quality
package ccm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_SEL_HIST = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DRIVE = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_FORMAT = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_REF = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_STATIC_HOLD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_HISTORY_AVERAGING = 8'h09;

  // ************************************************************
  // Reset values and writable-bit masks
  // ************************************************************
  localparam logic [DATA_W-1:0] RST_SEL_HIST = 8'h12;
  localparam logic [DATA_W-1:0] RST_DRIVE = 8'hED;
  localparam logic [DATA_W-1:0] RST_FORMAT = 8'h2D;
  localparam logic [DATA_W-1:0] RST_ALARM_REF = 8'h00;
  localparam logic [DATA_W-1:0] RST_STATIC_HOLD = 8'h00;
  localparam logic [DATA_W-1:0] RST_HISTORY_AVERAGING = 8'hC0;
  localparam logic [DATA_W-1:0] WMASK_SEL_HIST = 8'hDF;
  localparam logic [DATA_W-1:0] WMASK_DRIVE = 8'hC0;
  localparam logic [DATA_W-1:0] WMASK_FORMAT = 8'h7F;
  localparam logic [DATA_W-1:0] WMASK_ALARM_REF = 8'h07;
  localparam logic [DATA_W-1:0] WMASK_STATIC_HOLD = 8'hF0;
  localparam logic [DATA_W-1:0] WMASK_HISTORY_AVERAGING = 8'hF8;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int METHOD_LSB = 6;
  localparam int HDELAY_LSB = 0;
  localparam int HAVG_LSB = 3;
  localparam int HIST_W = 5;
  localparam int DRIVE_LSB = 6;
  localparam int SLEEP_BIT = 6;
  localparam int FMT_B_LSB = 3;
  localparam int FMT_A_LSB = 0;
  localparam int ALARM_LSB = 0;
  localparam int HOLD_B_LSB = 6;
  localparam int HOLD_A_LSB = 4;
  localparam int NUM_OUT = 2;

  // ************************************************************
  // Encodings
  // ************************************************************
  typedef enum logic [1:0] {
    METH_MANUAL = 2'h0,
    METH_AUTO_NONREV = 2'h1,
    METH_AUTO_REV = 2'h2,
    METH_RSVD = 2'h3
  } ccm_method_type;

  typedef enum logic [2:0] {
    FMT_RSVD0 = 3'h0,
    FMT_DISABLE = 3'h1,
    FMT_CMOS = 3'h2,
    FMT_LOW_SWING_LVDS = 3'h3,
    FMT_RSVD4 = 3'h4,
    FMT_LVPECL = 3'h5,
    FMT_CML = 3'h6,
    FMT_LVDS = 3'h7
  } ccm_format_type;

  typedef enum logic [1:0] {
    HOLD_NONE = 2'h0,
    HOLD_LOW = 2'h1,
    HOLD_HIGH = 2'h2,
    HOLD_RSVD = 2'h3
  } ccm_hold_type;

  typedef enum logic [2:0] {
    ALARM_REF_CRYSTAL = 3'h0,
    ALARM_REF_IN_A = 3'h1,
    ALARM_REF_IN_B = 3'h2
  } ccm_alarm_ref_type;

  typedef enum logic [1:0] {
    IN_A = 2'h0,
    IN_B = 2'h1
  } ccm_input_type;

  typedef enum logic [1:0] {
    SEL_FIRST = 2'h0,
    SEL_SECOND = 2'h1,
    SEL_HOLD = 2'h3,
    SEL_MANUAL = 2'h2
  } ccm_sel_state_type;

  // Host register access, one request per cycle
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } ccm_reg_req_type;

  // Selection controls held outside this register range
  typedef struct packed {
    logic pinSelectEnable;
    logic selectPin;
    logic [1:0] registerInputChoice;
    logic [1:0] firstPriorityInput;
    logic [1:0] secondPriorityInput;
    logic forceHold;
  } ccm_sel_ctrl_type;

endpackage : ccm_pkg

// file: tb_clock_select_output_format_regs.sv
// Self-checking bench for the clock-select and output-format registers.
// Assumes ccm_pkg, the design, the checker and the host model.
`timescale 1ns/10ps
`default_nettype none
module tb_clock_select_output_format_regs;
  import ccm_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  ccm_reg_req_type regReq;
  ccm_sel_ctrl_type selCtrl = '0;
  logic clockInAValid = 1'b1;
  logic clockInBValid = 1'b1;
  logic [1:0] pllClk = 2'h0;
  logic [7:0] rdData, q, a;
  logic rdValid, sleepMode, digitalHold, v;
  ccm_method_type selectMethod;
  logic [4:0] historyDelay, historyAveraging;
  logic [1:0] cmosDriveLevel, bypassAllowed, clockOut, outHolding;
  ccm_format_type outAFormat, outBFormat;
  logic [2:0] offsetAlarmReference;
  ccm_input_type activeInput;
  logic [7:0] shadow [4:9];
  int num_errors = 0;
  int compares = 0;
  always #25 clk = ~clk;
  always @(posedge clk) pllClk <= ~pllClk;
  ccm_cfg_regs dut (.clk, .arst_n, .regReq, .selCtrl, .clockInAValid,
    .clockInBValid, .pllClk, .rdData, .rdValid, .selectMethod,
    .historyDelay, .historyAveraging, .cmosDriveLevel, .sleepMode,
    .outAFormat, .outBFormat, .offsetAlarmReference, .bypassAllowed,
    .activeInput, .digitalHold, .clockOut, .outHolding);
  ccm_host_model host (.clk, .rdData, .rdValid, .regReq);
  // ********
  // Expectations and checks
  // ********
  function automatic logic [15:0] regInfo(input logic [7:0] ad);
    case (ad)
      ADDR_SEL_HIST: return {RST_SEL_HIST, WMASK_SEL_HIST};
      ADDR_DRIVE: return {RST_DRIVE, WMASK_DRIVE};
      ADDR_FORMAT: return {RST_FORMAT, WMASK_FORMAT};
      ADDR_ALARM_REF: return {RST_ALARM_REF, WMASK_ALARM_REF};
      ADDR_STATIC_HOLD: return {RST_STATIC_HOLD, WMASK_STATIC_HOLD};
      ADDR_HISTORY_AVERAGING: return {RST_HISTORY_AVERAGING, WMASK_HISTORY_AVERAGING};
      default: return {RD_UNMAPPED, 8'h00};
    endcase
  endfunction : regInfo
  // Steer clear of reserved codes; hold high only in directed steps
  function automatic logic [7:0] legal(input logic [7:0] ad, d);
    logic [7:0] r;
    r = d;
    if (ad == ADDR_SEL_HIST && r[7]) r[6] = 1'b0;
    if (ad == ADDR_FORMAT) r[3:0] = r[3:0] | {~r[4], 2'h0, ~r[1]};
    if (ad == ADDR_ALARM_REF) r[2:0] = {1'b0, r[1], r[0] & ~r[1]};
    if (ad == ADDR_STATIC_HOLD) r = r & 8'h5F;
    return r;
  endfunction : legal
  function automatic logic byp(input logic [2:0] c, input logic sl);
    return !sl && c inside {3'h3, 3'h5, 3'h6, 3'h7};
  endfunction : byp
  task automatic chk(input logic [7:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] ad, d);
    logic [7:0] m;
    m = regInfo(ad);
    host.acc(1'b1, 1'b0, ad, d, q, v);
    if (ad inside {[8'h04:8'h09]}) shadow[ad] = shadow[ad] & ~m | d & m;
  endtask : wreg
  task automatic chkFields;
    logic sl;
    sl = shadow[6][SLEEP_BIT];
    @(negedge clk);
    chk(selectMethod, shadow[4][7:6], "method");
    chk(historyDelay, shadow[4][4:0], "delay");
    chk(historyAveraging, shadow[9][7:3], "avg");
    chk(cmosDriveLevel, shadow[5][7:6], "drive");
    chk(sleepMode, sl, "sleep");
    chk(outBFormat, sl ? 3'h1 : shadow[6][5:3], "format B");
    chk(outAFormat, sl ? 3'h1 : shadow[6][2:0], "format A");
    chk(bypassAllowed, {byp(shadow[6][5:3], sl), byp(shadow[6][2:0], sl)},
        "bypass");
    chk(offsetAlarmReference, shadow[7][2:0], "alarm ref");
  endtask : chkFields
  task automatic chkOut;
    logic [1:0] s0, h;
    logic off;
    repeat (4) @(negedge clk);
    s0 = clockOut;
    @(negedge clk);
    for (int i = 0; i < 2; i++) begin
      off = shadow[6][SLEEP_BIT] || shadow[6][3*i +: 3] == 3'h1;
      h = shadow[8][4+2*i +: 2];
      if (off || h == 2'h1) chk(clockOut[i] | s0[i], 1'b0, "low");
      else if (h == 2'h2) chk(clockOut[i] & s0[i], 1'b1, "high");
      else chk(clockOut[i] ^ s0[i], 1'b1, "follow");
      chk(outHolding[i], off || h != 2'h0, "holding");
    end
  endtask : chkOut
  task automatic selCase(input logic [7:0] r4, input logic [8:0] c,
      input logic va, vb, input ccm_input_type e, input logic h);
    if (r4 !== shadow[4]) wreg(ADDR_SEL_HIST, r4);
    @(posedge clk);
    selCtrl <= c;
    clockInAValid <= va;
    clockInBValid <= vb;
    repeat (4) @(negedge clk);
    chk(activeInput, e, "input");
    chk(digitalHold, h, "digital hold");
  endtask : selCase
  task automatic final_report;
    $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // ********
  // Sequence
  // ********
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
  initial begin
    void'($urandom(58633));
    for (int i = 4; i < 10; i++) shadow[i] = regInfo(8'(i)) >> 8;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 3; i < 11; i++) begin
      host.acc(1'b0, 1'b1, 8'(i), 8'h00, q, v);
      chk(q, regInfo(8'(i)) >> 8, "reset value");
    end
    chkFields();
    $display("test reset done");
    foreach (shadow[i]) begin
      wreg(8'h08, i == 4 || i == 7 ? 8'hA0 : i == 6 ? 8'h50 : 8'h00);
      chkOut();
    end
    $display("test hold done");
    host.acc(1'b1, 1'b1, ADDR_HISTORY_AVERAGING, 8'h5F, q, v);
    chk(q, 8'hC0, "read beside write");
    shadow[9] = 8'h58;
    for (int n = 0; n < 40; n++) begin
      a = 8'h03 + 8'($urandom_range(7));
      wreg(a, legal(a, 8'($urandom)));
      host.acc(1'b0, 1'b1, a, 8'h00, q, v);
      chk(v, 1'b1, "read valid");
      chk(q, a inside {[8'h04:8'h09]} ? shadow[a] : RD_UNMAPPED, "rd");
      chkFields();
      chkOut();
    end
    $display("test registers done");
    selCase(8'h12, 9'h020, 1'b1, 1'b1, IN_B, 1'b0);
    selCase(8'h12, 9'h120, 1'b1, 1'b1, IN_A, 1'b0);
    selCase(8'h12, 9'h180, 1'b1, 1'b1, IN_B, 1'b0);
    selCase(8'h92, 9'h008, 1'b1, 1'b0, IN_A, 1'b0);
    selCase(8'h92, 9'h008, 1'b1, 1'b1, IN_B, 1'b0);
    selCase(8'h92, 9'h002, 1'b1, 1'b1, IN_A, 1'b0);
    selCase(8'h52, 9'h002, 1'b0, 1'b1, IN_B, 1'b0);
    selCase(8'h52, 9'h002, 1'b1, 1'b1, IN_B, 1'b0);
    selCase(8'h52, 9'h003, 1'b1, 1'b1, IN_B, 1'b1);
    selCase(8'h52, 9'h002, 1'b1, 1'b1, IN_A, 1'b0);
    $display("test select done");
    final_report();
  end
endmodule : tb_clock_select_output_format_regs
`default_nettype wire
